// File: design/iatc_top.sv
`timescale 1ns/100ps
`include "iatc_defs.svh"
// Functional notes
// RULE1: software origin: each fire command gives exactly one trigger occurrence.
// RULE2: hardware origin: each valid edge on line 1 gives one occurrence.
// RULE3: shared trigger settings land only in the selected trigger's storage.
// RULE4: fire command goes to the trigger the selector points at.
// RULE5: software frame trigger: exposure lasts the programmed duration value.
// RULE6: hardware frame trigger: timed policy or pulse-width policy exposure.
// RULE7: no frame is captured before a start command arms capture.
// RULE8: stop with no frame in progress disarms at once.
// RULE9: stop during a frame completes it, then disarms, no new triggers.
// RULE10: single-frame policy disarms itself after one completed frame.
// RULE11: continuous policy captures one frame per trigger until stopped.
// RULE12: single-frame policy runs full setup, no exposure/readout overlap.
// RULE13: frame triggers outside waiting-for-frame status are ignored.
// RULE14: frame count 1..255; after that many frames, wait for acquisition trigger.
// RULE15: line 1 synchronised, selected edge detected as one-cycle pulse.
module iatc_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire iatc_pkg::iatc_word_t wb_dat_i,
	output iatc_pkg::iatc_word_t wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	input wire logic line1_i,
	output logic exposing_o,
	output logic armed_o,
	output iatc_pkg::iatc_word_t frame_data_o,
	output logic frame_valid_o,
	input wire logic frame_ready_i
);
	import iatc_pkg::*;

	iatc_state_e state_reg;
	logic acq_en_reg, acq_hw_reg, acq_fall_reg;
	logic frm_en_reg, frm_hw_reg, frm_fall_reg;
	logic cont_reg, sel_frm_reg, width_pol_reg;
	logic [31:0] shut_reg;
	logic [7:0] fcnt_reg;
	logic [15:0] setup_len_reg, read_len_reg;
	logic armed_reg, stop_pend_reg;
	logic [7:0] fdone_reg;
	logic [31:0] tmr_reg;
	logic [31:0] frame_no_reg;
	logic sync1_reg, sync2_reg, sync3_reg;
	logic ack_reg, err_reg;
	iatc_word_t rdat_reg;
	logic fire_acq, fire_frm, start_cmd, stop_cmd;
	logic rise, fall, hw_end;
	logic acq_trig, frm_trig;
	logic wr, rd, req;
	logic fifo_in_ready;
	logic [`IATC_FIFO_AW:0] fifo_level;

	assign req = wb_cyc_i && wb_stb_i && !ack_reg && !err_reg;
	assign wr = req && wb_we_i && wb_sel_i[0];
	assign rd = req && !wb_we_i;
	assign wb_ack_o = ack_reg;
	assign wb_err_o = err_reg;
	assign wb_dat_o = rdat_reg;

	// commands are write-one pulses
	assign start_cmd = wr && wb_adr_i == `IATC_ADR_CMD && wb_dat_i[`IATC_CMD_START];
	assign stop_cmd = wr && wb_adr_i == `IATC_ADR_CMD && wb_dat_i[`IATC_CMD_STOP];
	assign fire_acq = wr && wb_adr_i == `IATC_ADR_CMD && wb_dat_i[`IATC_CMD_FIRE] && !sel_frm_reg; // RULE4
	assign fire_frm = wr && wb_adr_i == `IATC_ADR_CMD && wb_dat_i[`IATC_CMD_FIRE] && sel_frm_reg; // RULE4

	// only sync2 and sync3 are inspected; sync1 is metastability stage
	assign rise = sync2_reg && !sync3_reg;
	assign fall = !sync2_reg && sync3_reg;
	assign hw_end = frm_fall_reg ? rise : fall;

	always_comb begin
		acq_trig = 1'b0;
		if (!acq_en_reg) begin
			acq_trig = 1'b1;
		end else if (acq_hw_reg) begin
			acq_trig = acq_fall_reg ? fall : rise; // RULE2 RULE15
		end else begin
			acq_trig = fire_acq; // RULE1
		end
	end

	always_comb begin
		frm_trig = 1'b0;
		if (!frm_en_reg) begin
			frm_trig = 1'b1;
		end else if (frm_hw_reg) begin
			frm_trig = frm_fall_reg ? fall : rise; // RULE2 RULE15
		end else begin
			frm_trig = fire_frm; // RULE1
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end else begin
			sync1_reg <= line1_i; // RULE15
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	// bus slave: one wait-free answer, ack or err one cycle after request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			rdat_reg <= '0;
		end else begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
			if (req) begin
				if (wb_adr_i == `IATC_ADR_CTRL || wb_adr_i == `IATC_ADR_TRIG || wb_adr_i == `IATC_ADR_CMD
					|| wb_adr_i == `IATC_ADR_SHUT || wb_adr_i == `IATC_ADR_FCNT || wb_adr_i == `IATC_ADR_SETUP
					|| wb_adr_i == `IATC_ADR_READ || wb_adr_i == `IATC_ADR_STAT || wb_adr_i == `IATC_ADR_FIFO) begin
					ack_reg <= 1'b1;
				end else begin
					err_reg <= 1'b1;
				end
			end
			if (rd) begin
				if (wb_adr_i == `IATC_ADR_CTRL) begin
					rdat_reg <= {29'h0, width_pol_reg, sel_frm_reg, cont_reg};
				end else if (wb_adr_i == `IATC_ADR_TRIG) begin
					rdat_reg <= sel_frm_reg ? {29'h0, frm_fall_reg, frm_hw_reg, frm_en_reg}
						: {29'h0, acq_fall_reg, acq_hw_reg, acq_en_reg};
				end else if (wb_adr_i == `IATC_ADR_SHUT) begin
					rdat_reg <= shut_reg;
				end else if (wb_adr_i == `IATC_ADR_FCNT) begin
					rdat_reg <= {24'h0, fcnt_reg};
				end else if (wb_adr_i == `IATC_ADR_SETUP) begin
					rdat_reg <= {16'h0, setup_len_reg};
				end else if (wb_adr_i == `IATC_ADR_READ) begin
					rdat_reg <= {16'h0, read_len_reg};
				end else if (wb_adr_i == `IATC_ADR_STAT) begin
					rdat_reg <= {16'h0, 3'h0, fifo_level, stop_pend_reg, armed_reg, 2'h0, 1'b0, state_reg};
				end else if (wb_adr_i == `IATC_ADR_FIFO) begin
					rdat_reg <= frame_no_reg;
				end else begin
					rdat_reg <= '0;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cont_reg <= 1'b0;
			sel_frm_reg <= 1'b0;
			width_pol_reg <= 1'b0;
			acq_en_reg <= 1'b0;
			acq_hw_reg <= 1'b0;
			acq_fall_reg <= 1'b0;
			frm_en_reg <= 1'b0;
			frm_hw_reg <= 1'b0;
			frm_fall_reg <= 1'b0;
			shut_reg <= `IATC_SHUT_RST;
			fcnt_reg <= `IATC_FCNT_RST;
			setup_len_reg <= `IATC_SETUP_RST;
			read_len_reg <= `IATC_READ_RST;
		end else if (wr) begin
			if (wb_adr_i == `IATC_ADR_CTRL) begin
				cont_reg <= wb_dat_i[`IATC_CTRL_CONT];
				sel_frm_reg <= wb_dat_i[`IATC_CTRL_SEL];
				width_pol_reg <= wb_dat_i[`IATC_CTRL_POL];
			end else if (wb_adr_i == `IATC_ADR_TRIG && sel_frm_reg) begin
				frm_en_reg <= wb_dat_i[`IATC_TRIG_EN]; // RULE3
				frm_hw_reg <= wb_dat_i[`IATC_TRIG_HW];
				frm_fall_reg <= wb_dat_i[`IATC_TRIG_FALL];
			end else if (wb_adr_i == `IATC_ADR_TRIG) begin
				acq_en_reg <= wb_dat_i[`IATC_TRIG_EN]; // RULE3
				acq_hw_reg <= wb_dat_i[`IATC_TRIG_HW];
				acq_fall_reg <= wb_dat_i[`IATC_TRIG_FALL];
			end else if (wb_adr_i == `IATC_ADR_SHUT && wb_sel_i == 4'hf) begin
				shut_reg <= wb_dat_i;
			end else if (wb_adr_i == `IATC_ADR_FCNT) begin
				// zero is out of range; clamp to the least count
				fcnt_reg <= (wb_dat_i[7:0] == 8'h00) ? `IATC_FCNT_MIN : wb_dat_i[7:0]; // RULE14
			end else if (wb_adr_i == `IATC_ADR_SETUP && wb_sel_i[1]) begin
				setup_len_reg <= wb_dat_i[15:0];
			end else if (wb_adr_i == `IATC_ADR_READ && wb_sel_i[1]) begin
				read_len_reg <= wb_dat_i[15:0];
			end
		end
	end

	// armed flag: start sets, stop clears or defers to frame end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			armed_reg <= 1'b0;
			stop_pend_reg <= 1'b0;
		end else if (start_cmd && !armed_reg) begin
			armed_reg <= 1'b1; // RULE7
			stop_pend_reg <= 1'b0;
		end else if (stop_cmd && (state_reg == IATC_WAIT_ACQ || state_reg == IATC_WAIT_FRM
			|| state_reg == IATC_IDLE)) begin
			armed_reg <= 1'b0; // RULE8
			stop_pend_reg <= 1'b0;
		end else if (state_reg == IATC_PUSH && fifo_in_ready
			&& (stop_pend_reg || stop_cmd || !cont_reg)) begin
			// a stop landing on the frame's last cycle must not leak one more frame
			armed_reg <= 1'b0; // RULE9 RULE10
			stop_pend_reg <= 1'b0;
		end else if (stop_cmd) begin
			stop_pend_reg <= 1'b1; // RULE9
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= IATC_IDLE;
			tmr_reg <= '0;
			fdone_reg <= '0;
			frame_no_reg <= '0;
		end else begin
			case (state_reg)
				IATC_IDLE: begin
					fdone_reg <= '0;
					if (armed_reg && !stop_cmd) begin
						state_reg <= IATC_WAIT_ACQ; // RULE7
					end
				end
				IATC_WAIT_ACQ: begin
					fdone_reg <= '0;
					if (!armed_reg || stop_cmd) begin
						state_reg <= IATC_IDLE;
					end else if (acq_trig) begin
						state_reg <= IATC_WAIT_FRM;
					end
				end
				IATC_WAIT_FRM: begin
					if (!armed_reg || stop_cmd) begin
						state_reg <= IATC_IDLE;
					end else if (frm_trig) begin
						state_reg <= IATC_SETUP; // RULE13 RULE11
						tmr_reg <= {16'h0, setup_len_reg};
						fdone_reg <= fdone_reg + 8'h01;
					end
				end
				IATC_SETUP: begin
					// single-frame pays a full setup; continuous spends one cycle here
					if (tmr_reg == '0 || cont_reg) begin
						state_reg <= IATC_EXPOSE; // RULE12
						tmr_reg <= shut_reg; // RULE5
					end else begin
						tmr_reg <= tmr_reg - 32'h1;
					end
				end
				IATC_EXPOSE: begin
					if ((frm_en_reg && frm_hw_reg && width_pol_reg) ? hw_end : (tmr_reg <= 32'h1)) begin
						state_reg <= IATC_READOUT; // RULE6
						tmr_reg <= {16'h0, read_len_reg};
					end else begin
						tmr_reg <= tmr_reg - 32'h1;
					end
				end
				IATC_READOUT: begin
					// exposure never restarts until readout ends
					if (tmr_reg == '0) begin
						state_reg <= IATC_PUSH; // RULE12
					end else begin
						tmr_reg <= tmr_reg - 32'h1;
					end
				end
				IATC_PUSH: begin
					if (fifo_in_ready) begin
						frame_no_reg <= frame_no_reg + 32'h1;
						if (stop_pend_reg || stop_cmd || !cont_reg) begin
							state_reg <= IATC_IDLE; // RULE9 RULE10
						end else if (acq_en_reg && fdone_reg >= fcnt_reg) begin
							state_reg <= IATC_WAIT_ACQ; // RULE14
						end else begin
							state_reg <= IATC_WAIT_FRM; // RULE11
						end
					end
				end
				default: begin
					state_reg <= IATC_IDLE;
				end
			endcase
		end
	end

	assign exposing_o = state_reg == IATC_EXPOSE;
	assign armed_o = armed_reg;

	// frame records: sequence number, stalls frame end when full
	iatc_fifo #(
		.WIDTH(`IATC_FIFO_W),
		.DEPTH(`IATC_FIFO_D),
		.AW(`IATC_FIFO_AW)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_data_i(frame_no_reg),
		.in_valid_i(state_reg == IATC_PUSH),
		.in_ready_o(fifo_in_ready),
		.out_data_o(frame_data_o),
		.out_valid_o(frame_valid_o),
		.out_ready_i(frame_ready_i),
		.level_o(fifo_level)
	);
endmodule

// File: inc/iatc_defs.svh
`ifndef IATC_DEFS_SVH
`define IATC_DEFS_SVH
// register byte offsets
`define IATC_ADR_CTRL 8'h00
`define IATC_ADR_TRIG 8'h04
`define IATC_ADR_CMD 8'h08
`define IATC_ADR_SHUT 8'h0c
`define IATC_ADR_FCNT 8'h10
`define IATC_ADR_SETUP 8'h14
`define IATC_ADR_READ 8'h18
`define IATC_ADR_STAT 8'h1c
`define IATC_ADR_FIFO 8'h20
// ctrl fields
`define IATC_CTRL_CONT 0
`define IATC_CTRL_SEL 1
`define IATC_CTRL_POL 2
// trig fields (shared group)
`define IATC_TRIG_EN 0
`define IATC_TRIG_HW 1
`define IATC_TRIG_FALL 2
// cmd fields, self clearing
`define IATC_CMD_START 0
`define IATC_CMD_STOP 1
`define IATC_CMD_FIRE 2
// reset values, least frame count, fifo sizing
`define IATC_SHUT_RST 32'h000003e8
`define IATC_FCNT_RST 8'h01
`define IATC_SETUP_RST 16'h0010
`define IATC_READ_RST 16'h0020
`define IATC_FCNT_MIN 8'h01
`define IATC_FIFO_W 32
`define IATC_FIFO_D 16
`define IATC_FIFO_AW 4
`endif

// File: inc/iatc_pkg.sv
package iatc_pkg;
	typedef enum logic [2:0] {
		IATC_IDLE,
		IATC_WAIT_ACQ,
		IATC_WAIT_FRM,
		IATC_SETUP,
		IATC_EXPOSE,
		IATC_READOUT,
		IATC_PUSH
	} iatc_state_e;
	typedef logic [31:0] iatc_word_t;
endpackage

// File: design/iatc_fifo.sv
`timescale 1ns/100ps
module iatc_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [WIDTH-1:0] in_data_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	output logic [WIDTH-1:0] out_data_o,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [AW:0] level_o
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;

	assign in_ready_o = int'(cnt_reg) < DEPTH;
	assign out_valid_o = cnt_reg != '0;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem[rd_reg];
	assign level_o = cnt_reg;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
			if (push && !pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end
endmodule

// File: sim/iatc_asserts.sv
`timescale 1ns/100ps
module iatc_asserts (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire iatc_pkg::iatc_word_t wb_dat_i,
	input wire iatc_pkg::iatc_word_t wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic wb_err_o,
	input wire logic line1_i,
	input wire logic exposing_o,
	input wire logic armed_o,
	input wire iatc_pkg::iatc_word_t frame_data_o,
	input wire logic frame_valid_o,
	input wire logic frame_ready_i
);
	import iatc_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence
	sequence s_ans;
		(wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
	endsequence
	chk_bus_answer: assert property (s_req |=> s_ans) else $error("request not answered once");
	chk_ack_cause: assert property (wb_ack_o || wb_err_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray answer");
	chk_err_unmapped: assert property (s_req and wb_adr_i > 8'h20 |=> wb_err_o) else $error("no error");
	chk_ack_mapped: assert property (s_req and wb_adr_i[1:0] == 2'h0 and wb_adr_i <= 8'h20 |=> wb_ack_o)
		else $error("no ack");
	chk_expose_armed: assert property (exposing_o |-> armed_o) else $error("exposure while disarmed");
	chk_arm_quiet: assert property (!armed_o |=> !$rose(exposing_o)) else $error("exposure unarmed");
	chk_disarm_done: assert property ($fell(armed_o) |-> !exposing_o && !$past(exposing_o))
		else $error("disarm mid exposure");
	chk_stream_hold: assert property (frame_valid_o && !frame_ready_i |=> frame_valid_o && $stable(frame_data_o))
		else $error("stream head changed");
endmodule
bind iatc_top iatc_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .line1_i(line1_i), .exposing_o(exposing_o), .armed_o(armed_o),
	.frame_data_o(frame_data_o), .frame_valid_o(frame_valid_o), .frame_ready_i(frame_ready_i));

// File: sim/iatc_src.sv
`timescale 1ns/100ps
module iatc_src (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic frame_valid_i,
	input wire iatc_pkg::iatc_word_t frame_data_i,
	output logic line1_o,
	output logic frame_ready_o
);
	import iatc_pkg::*;
	logic stall = 0;
	int pops = 0;
	int bad = 0;
	iatc_word_t last;
	initial line1_o = 0;
	assign frame_ready_o = !stall;
	// frame numbers must climb by one per popped frame
	always @(posedge clk_i) begin
		if (!rst_i && frame_valid_i === 1 && frame_ready_o) begin
			if (pops > 0 && frame_data_i !== last + 32'h1)
				bad++;
			last = frame_data_i;
			pops++;
		end
	end
	task pulse(input int w);
		@(posedge clk_i);
		line1_o <= 1;
		repeat (w) @(posedge clk_i);
		line1_o <= 0;
	endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/100ps
module tb;
	import iatc_pkg::*;
	typedef struct packed {logic [7:0] a; logic wr; iatc_word_t d; iatc_word_t x;} iatc_row_s;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, line1, rdy, ack, err, expo, armed, fv, e;
	logic [7:0] adr = 8'h00;
	iatc_word_t dw = 32'h0, dr, fd, q;
	int fail_count = 0, tests_run = 0, len, w, p;
	iatc_row_s rows [10] = '{'{8'h0c, 0, 0, 32'h3e8}, '{8'h10, 0, 0, 32'h1}, '{8'h14, 0, 0, 32'h10},
		'{8'h18, 0, 0, 32'h20}, '{8'h1c, 0, 0, 32'h0}, '{8'h0c, 1, 32'h14, 32'h14},
		'{8'h10, 1, 32'h0, 32'h1}, '{8'h10, 1, 32'hff, 32'hff},
		'{8'h14, 1, 32'h4, 32'h4}, '{8'h18, 1, 32'h8, 32'h8}};
	always #5 clk_i = ~clk_i;
	iatc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .wb_err_o(err), .line1_i(line1),
		.exposing_o(expo), .armed_o(armed), .frame_data_o(fd), .frame_valid_o(fv), .frame_ready_i(rdy));
	iatc_src u_src (.clk_i(clk_i), .rst_i(rst_i), .frame_valid_i(fv), .frame_data_i(fd), .line1_o(line1),
		.frame_ready_o(rdy));
	task chk(input iatc_word_t g, input iatc_word_t x);
		tests_run++;
		if (g !== x) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task bus(input logic [7:0] a, input logic wr, input iatc_word_t d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= wr;
		adr <= a;
		dw <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1 && err !== 1 && n < 40);
		if (ack !== 1 && err !== 1) begin
			fail_count++;
			$display("ERROR t=%0t bus timeout adr=%h", $time, a);
		end
		q = dr;
		e = err;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask
	// exposure length and the wait before it; len stays 0 if none starts
	task ex;
		len = 0;
		w = 0;
		while (expo !== 1 && w < 80) begin
			@(posedge clk_i);
			w++;
		end
		while (expo === 1 && len < 300) begin
			@(posedge clk_i);
			len++;
		end
	endtask
	task cmd(input iatc_word_t c);
		bus(8'h08, 1, c);
	endtask
	task done(input string s);
		$display("test %s done", s);
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		final_report;
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		foreach (rows[i]) begin
			if (rows[i].wr)
				bus(rows[i].a, 1, rows[i].d);
			bus(rows[i].a, 0, 0);
			chk(q, rows[i].x);
		end
		bus(8'h24, 0, 0);
		chk(32'(e), 32'h1);
		done("registers");
		bus(8'h00, 1, 32'h0);
		bus(8'h04, 1, 32'h4);
		bus(8'h00, 1, 32'h2);
		bus(8'h04, 1, 32'h1);
		bus(8'h00, 1, 32'h0);
		bus(8'h04, 0, 0);
		chk(q, 32'h4);
		bus(8'h00, 1, 32'h2);
		cmd(32'h4);
		ex;
		chk(32'(len), 32'h0);
		cmd(32'h1);
		chk(32'(armed), 32'h1);
		cmd(32'h4);
		ex;
		chk(32'(len), 32'h14);
		chk(32'(w), 32'h4);
		repeat (40) @(posedge clk_i);
		chk(32'(armed), 32'h0);
		cmd(32'h4);
		ex;
		chk(32'(len), 32'h0);
		chk(32'(u_src.pops), 32'h1);
		done("single");
		bus(8'h00, 1, 32'h3);
		bus(8'h04, 1, 32'h3);
		cmd(32'h1);
		fork
			u_src.pulse(5);
			ex;
		join
		chk(32'(len), 32'h14);
		repeat (40) @(posedge clk_i);
		u_src.pulse(5);
		cmd(32'h2);
		chk(32'(armed & expo), 32'h1);
		repeat (60) @(posedge clk_i);
		chk(32'(armed), 32'h0);
		chk(32'(u_src.pops), 32'h3);
		u_src.pulse(5);
		ex;
		chk(32'(len), 32'h0);
		done("stop mid frame");
		bus(8'h00, 1, 32'h7);
		cmd(32'h1);
		fork
			u_src.pulse(30);
			ex;
		join
		// the one continuous setup cycle trims the gate by one
		chk(32'(len), 32'h1d);
		repeat (40) @(posedge clk_i);
		cmd(32'h2);
		chk(32'(armed), 32'h0);
		bus(8'h04, 1, 32'h7);
		bus(8'h00, 1, 32'h3);
		cmd(32'h1);
		fork
			u_src.pulse(5);
			ex;
		join
		chk(32'(len), 32'h14);
		repeat (40) @(posedge clk_i);
		cmd(32'h2);
		chk(32'(armed), 32'h0);
		done("pulse width");
		bus(8'h00, 1, 32'h3);
		bus(8'h04, 1, 32'h1);
		@(posedge clk_i) u_src.stall <= 1;
		cmd(32'h1);
		p = u_src.pops;
		repeat (18) begin
			cmd(32'h4);
			repeat (40) @(posedge clk_i);
		end
		bus(8'h1c, 0, 0);
		chk(32'(q[12:8]), 32'h10);
		@(posedge clk_i) u_src.stall <= 0;
		repeat (100) @(posedge clk_i);
		chk(32'(u_src.pops - p), 32'h11);
		chk(32'(u_src.bad), 32'h0);
		done("fifo");
		cmd(32'h2);
		bus(8'h10, 1, 32'h2);
		bus(8'h00, 1, 32'h1);
		bus(8'h04, 1, 32'h1);
		bus(8'h00, 1, 32'h3);
		cmd(32'h1);
		p = u_src.pops;
		cmd(32'h4);
		ex;
		chk(32'(len), 32'h0);
		bus(8'h00, 1, 32'h1);
		cmd(32'h4);
		bus(8'h00, 1, 32'h3);
		repeat (3) begin
			cmd(32'h4);
			repeat (60) @(posedge clk_i);
		end
		chk(32'(u_src.pops - p), 32'h2);
		done("frame count");
		final_report;
	end
endmodule
